// ===== rtl/card_socket_power_clock_ctrl.v
// Socket voltage control and socket clock power management registers with card clock policy.
`timescale 1ns/10ps
`include "card_socket_regs.vh"
module card_socket_power_clock_ctrl (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Reset pins from outside, both active low
   input wire globalResetPin_n,
   input wire hostBusResetPin_n,
   // PME enable from the power management function
   input wire pmeEnable,
   // Register port
   input wire [7:0] regAddr,
   input wire [31:0] regWrData,
   input wire regWrite,
   input wire regRead,
   output reg [31:0] regRdData,
   // Card type and socket activity
   input wire card5vCapable,
   input wire card3vCapable,
   input wire socketBusy,
   input wire hostClockStopping,
   // Outputs to the socket power switch
   output reg [2:0] supplyVoltageRequest,
   output reg [2:0] programVoltageRequest,
   output reg supplyRequestRefused,
   // Card clock-run permissions
   output reg cardClockStopAllowed,
   output reg cardClockSlowAllowed,
   output reg cardClockDivEnable
);
   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   // All pins from outside the clock domain travel in one vector, two flip-flops per bit.
   localparam PIN_COUNT = 6;
   // Reset levels: both reset pins released, socket busy, no card fitness, host clock running.
   localparam [PIN_COUNT-1:0] PIN_IDLE = 6'h32;
   wire [PIN_COUNT-1:0] pinRaw = {globalResetPin_n, hostBusResetPin_n, card5vCapable, card3vCapable, socketBusy,
      hostClockStopping};
   wire [PIN_COUNT-1:0] pinSync;
   genvar pinIdx;
   generate
      for (pinIdx = 0; pinIdx < PIN_COUNT; pinIdx = pinIdx + 1) begin : pinSyncGen
         reg [1:0] stage_q;
         always @(posedge clk) begin
            if (rst) begin
               stage_q <= {2{PIN_IDLE[pinIdx]}};
            end else begin
               stage_q <= {stage_q[0], pinRaw[pinIdx]};
            end
         end
         assign pinSync[pinIdx] = stage_q[1];
      end
   endgenerate
   wire globalReset = ~pinSync[5];
   wire busReset = ~pinSync[4];
   wire card5v = pinSync[3];
   wire card3v = pinSync[2];
   wire socketBusySync = pinSync[1];
   wire hostStop = pinSync[0];

   // ----------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------
   reg clockStopPolicy_q;
   reg [2:0] supplyReq_q;
   reg [2:0] programReq_q;
   reg throttleEnable_q;
   reg throttleSelect_q;
   // Writes to unmapped offsets match neither strobe and are dropped.
   wire ctrlWrite = regWrite && (regAddr == `SOCKET_VOLTAGE_CONTROL_OFS);
   wire pmWrite = regWrite && (regAddr == `SOCKET_CLOCK_POWER_MGMT_OFS);
   wire [2:0] wrSupply = regWrData[`SUPPLY_REQ_HI:`SUPPLY_REQ_LO];
   wire [2:0] wrProgram = regWrData[`PROGRAM_REQ_HI:`PROGRAM_REQ_LO];
   // Context bits survive a bus reset while PME is on, so a wake-up keeps the socket powered.
   wire contextClear = globalReset || (busReset && !pmeEnable);

   // ----------------------------------------------------------------
   // Request checks against the card
   // ----------------------------------------------------------------
   // Only codes the card accepts are stored; others leave the field as it was.
   reg supplyOk;
   reg programOk;
   always @* begin
      case (wrSupply)
         `REQ_OFF: supplyOk = 1'b1;
         `REQ_SUPPLY_5V: supplyOk = card5v;
         `REQ_SUPPLY_3V3: supplyOk = card3v;
         default: supplyOk = 1'b0;
      endcase
      case (wrProgram)
         `REQ_OFF: programOk = 1'b1;
         `REQ_PROG_12V: programOk = 1'b1;
         `REQ_PROG_5V: programOk = card5v;
         `REQ_PROG_3V3: programOk = card3v;
         default: programOk = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // Voltage request fields
   // ----------------------------------------------------------------
   // A clear wins over a write that falls in the same cycle.
   reg [2:0] supplyReq_d;
   reg [2:0] programReq_d;
   always @* begin
      supplyReq_d = supplyReq_q;
      programReq_d = programReq_q;
      if (contextClear) begin
         supplyReq_d = `REQ_OFF;
         programReq_d = `REQ_OFF;
      end else if (ctrlWrite) begin
         if (supplyOk) begin
            supplyReq_d = wrSupply;
         end
         if (programOk) begin
            programReq_d = wrProgram;
         end
      end
   end
   always @(posedge clk) begin
      if (rst) begin
         supplyReq_q <= `REQ_OFF;
         programReq_q <= `REQ_OFF;
      end else begin
         supplyReq_q <= supplyReq_d;
         programReq_q <= programReq_d;
      end
   end

   // ----------------------------------------------------------------
   // Clock policy and throttle bits
   // ----------------------------------------------------------------
   // Either reset pin returns the policy and throttle bits to their idle values.
   wire clockClear = globalReset || busReset;
   reg clockStopPolicy_d;
   reg throttleEnable_d;
   reg throttleSelect_d;
   always @* begin
      clockStopPolicy_d = clockStopPolicy_q;
      throttleEnable_d = throttleEnable_q;
      throttleSelect_d = throttleSelect_q;
      if (clockClear) begin
         clockStopPolicy_d = 1'b0;
         throttleEnable_d = 1'b0;
         throttleSelect_d = 1'b0;
      end else begin
         if (ctrlWrite) begin
            clockStopPolicy_d = regWrData[`CLOCK_STOP_POLICY_BIT];
         end
         if (pmWrite) begin
            throttleEnable_d = regWrData[`THROTTLE_ENABLE_BIT];
            throttleSelect_d = regWrData[`THROTTLE_SELECT_BIT];
         end
      end
   end
   always @(posedge clk) begin
      if (rst) begin
         clockStopPolicy_q <= 1'b0;
         throttleEnable_q <= 1'b0;
         throttleSelect_q <= 1'b0;
      end else begin
         clockStopPolicy_q <= clockStopPolicy_d;
         throttleEnable_q <= throttleEnable_d;
         throttleSelect_q <= throttleSelect_d;
      end
   end

   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------
   // Unmapped offsets read as zero.
   reg [31:0] rdMux;
   always @* begin
      rdMux = 32'h00000000;
      case (regAddr)
         `SOCKET_VOLTAGE_CONTROL_OFS: begin
            rdMux[`FIXED_ONE_BIT] = 1'b1;
            rdMux[`CLOCK_STOP_POLICY_BIT] = clockStopPolicy_q;
            rdMux[`SUPPLY_REQ_HI:`SUPPLY_REQ_LO] = supplyReq_q;
            rdMux[`PROGRAM_REQ_HI:`PROGRAM_REQ_LO] = programReq_q;
         end
         `SOCKET_CLOCK_POWER_MGMT_OFS: begin
            rdMux[`THROTTLE_ENABLE_BIT] = throttleEnable_q;
            rdMux[`THROTTLE_SELECT_BIT] = throttleSelect_q;
         end
         default: rdMux = 32'h00000000;
      endcase
   end

   // Read data stand for the one cycle after the strobe; between reads the port shows zero.
   reg [31:0] rdData_d;
   always @* begin
      rdData_d = 32'h00000000;
      if (regRead) begin
         rdData_d = rdMux;
      end
   end
   always @(posedge clk) begin
      if (rst) begin
         regRdData <= 32'h00000000;
      end else begin
         regRdData <= rdData_d;
      end
   end

   // ----------------------------------------------------------------
   // Power switch outputs
   // ----------------------------------------------------------------
   // The refusal flag follows every control write and holds between them.
   reg refused_d;
   always @* begin
      refused_d = supplyRequestRefused;
      if (ctrlWrite) begin
         refused_d = !(supplyOk && programOk);
      end
   end
   always @(posedge clk) begin
      if (rst) begin
         supplyVoltageRequest <= `REQ_OFF;
         programVoltageRequest <= `REQ_OFF;
         supplyRequestRefused <= 1'b0;
      end else begin
         supplyVoltageRequest <= supplyReq_q;
         programVoltageRequest <= programReq_q;
         supplyRequestRefused <= refused_d;
      end
   end

   // ----------------------------------------------------------------
   // Card clock policy
   // ----------------------------------------------------------------
   wire idleEnough;
   socket_idle_counter #(
      .WIDTH(4),
      .LIMIT(`SOCKET_IDLE_CLOCKS)
   ) idleCount (
      .clk(clk),
      .rst(rst),
      .socketBusy(socketBusySync),
      .idleReached(idleEnough)
   );

   // ----------------------------------------------------------------
   // Card clock permissions
   // ----------------------------------------------------------------
   // Policy 0 waits for an idle socket and a host clock about to stop; policy 1 does not wait.
   wire waitMet = idleEnough && hostStop;
   wire policyMet = clockStopPolicy_q || waitMet;
   wire mayAct = throttleEnable_q && policyMet;

   // The select bit picks stopping or slowing, never both at once.
   reg stopAllowed_d;
   reg slowAllowed_d;
   always @* begin
      stopAllowed_d = 1'b0;
      slowAllowed_d = 1'b0;
      if (mayAct) begin
         if (throttleSelect_q) begin
            slowAllowed_d = 1'b1;
         end else begin
            stopAllowed_d = 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Slow clock divider
   // ----------------------------------------------------------------
   // Free-running count whose wrap gives a one-cycle enable every 16 clocks.
   reg [3:0] divCount_q;
   wire [3:0] divCount_d = divCount_q + 4'h1;
   wire divWrap = ({1'b0, divCount_q} == (`SLOW_DIVIDE - 5'h01));
   always @(posedge clk) begin
      if (rst) begin
         divCount_q <= 4'h0;
         cardClockStopAllowed <= 1'b0;
         cardClockSlowAllowed <= 1'b0;
         cardClockDivEnable <= 1'b0;
      end else begin
         divCount_q <= divCount_d;
         cardClockStopAllowed <= stopAllowed_d;
         cardClockSlowAllowed <= slowAllowed_d;
         cardClockDivEnable <= divWrap;
      end
   end
endmodule // card_socket_power_clock_ctrl

// ===== pkg/card_socket_regs.vh
// Register offsets, field positions, request codes and timing counts of the socket power and clock block.
`ifndef CARD_SOCKET_REGS_VH
`define CARD_SOCKET_REGS_VH
`define SOCKET_VOLTAGE_CONTROL_OFS 8'h10
`define SOCKET_CLOCK_POWER_MGMT_OFS 8'h20
`define CLOCK_STOP_POLICY_BIT 7
`define SUPPLY_REQ_HI 6
`define SUPPLY_REQ_LO 4
`define PROGRAM_REQ_HI 2
`define PROGRAM_REQ_LO 0
`define FIXED_ONE_BIT 10
`define THROTTLE_ENABLE_BIT 16
`define THROTTLE_SELECT_BIT 0
`define REQ_OFF 3'h0
`define REQ_SUPPLY_RSVD 3'h1
`define REQ_SUPPLY_5V 3'h2
`define REQ_SUPPLY_3V3 3'h3
`define REQ_PROG_12V 3'h1
`define REQ_PROG_5V 3'h2
`define REQ_PROG_3V3 3'h3
`define SOCKET_IDLE_CLOCKS 4'h8
`define SLOW_DIVIDE 5'h10
`endif

// ===== rtl/socket_idle_counter.v
// Counter that reports when the card socket has been idle for a set number of clocks.
`timescale 1ns/10ps
module socket_idle_counter #(
   parameter WIDTH = 4,
   parameter [WIDTH-1:0] LIMIT = 4'h8
) (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Activity in, idle out
   input wire socketBusy,
   output reg idleReached
);
   reg [WIDTH-1:0] count_q;
   always @(posedge clk) begin
      if (rst || socketBusy) begin
         count_q <= {WIDTH{1'b0}};
         idleReached <= 1'b0;
      end else begin
         if (count_q != LIMIT) begin
            count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
         end
         idleReached <= (count_q == LIMIT);
      end
   end
endmodule // socket_idle_counter

// ===== bench/card_socket_power_clock_ctrl_asserts.sv
// Port checks of the socket power and clock block.
`timescale 1ns/10ps
module card_socket_power_clock_ctrl_asserts (
   // Watched ports
   input wire clk, rst, globalResetPin_n, hostBusResetPin_n, pmeEnable, regWrite, regRead,
   input wire [7:0] regAddr,
   input wire [31:0] regWrData, regRdData,
   input wire card5vCapable, card3vCapable, socketBusy, hostClockStopping,
   input wire [2:0] supplyVoltageRequest, programVoltageRequest,
   input wire supplyRequestRefused, cardClockStopAllowed, cardClockSlowAllowed, cardClockDivEnable
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   AST_CTRL_READ: assert property ($past(regRead && regAddr == 8'h10) |-> regRdData[31:8] == 24'h4 && !regRdData[3])
      else $error("control read fixed bits wrong");
   AST_PM_READ: assert property ($past(regRead && regAddr == 8'h20) |-> !regRdData[31:17] && !regRdData[15:1])
      else $error("power management read fixed bits wrong");
   AST_SUPPLY_CODE: assert property (supplyVoltageRequest != 3'h1 && supplyVoltageRequest < 3'h4)
      else $error("supply request code illegal");
   AST_PROG_CODE: assert property (programVoltageRequest < 3'h4)
      else $error("program request code illegal");
   AST_SUPPLY_5V: assert property ($changed(supplyVoltageRequest) && supplyVoltageRequest == 3'h2 |-> $past(card5vCapable, 4))
      else $error("5V supply granted to unfit card");
   AST_REFUSE_CAUSE: assert property ($rose(supplyRequestRefused) |-> $past(regWrite && regAddr == 8'h10))
      else $error("refusal without control write");
   AST_OFF_WRITE: assert property (regWrite && regAddr == 8'h10 && regWrData[2:0] == 3'h0 |-> ##2 !programVoltageRequest)
      else $error("program off not applied in two cycles");
   AST_GLOBAL_CLEAR: assert property (!globalResetPin_n [*6] |-> !supplyVoltageRequest && !programVoltageRequest)
      else $error("global reset left requests set");
   AST_DIV_PULSE: assert property ($rose(cardClockDivEnable) |=> !cardClockDivEnable [*8])
      else $error("divider pulse too long or too soon");
   AST_STOP_SLOW: assert property (!(cardClockStopAllowed && cardClockSlowAllowed))
      else $error("stop and slow allowed together");
   cover property ($rose(supplyRequestRefused));
   cover property ($rose(cardClockDivEnable));
   cover property ($rose(cardClockStopAllowed));
endmodule // card_socket_power_clock_ctrl_asserts
bind card_socket_power_clock_ctrl card_socket_power_clock_ctrl_asserts chk_i (.clk, .rst, .globalResetPin_n,
   .hostBusResetPin_n, .pmeEnable, .regWrite, .regRead, .regAddr, .regWrData, .regRdData, .card5vCapable,
   .card3vCapable, .socketBusy, .hostClockStopping, .supplyVoltageRequest, .programVoltageRequest,
   .supplyRequestRefused, .cardClockStopAllowed, .cardClockSlowAllowed, .cardClockDivEnable);

// ===== bench/socket_power_switch_model.sv
// Socket power switch that applies the requested supplies.
`timescale 1ns/10ps
module socket_power_switch_model (
   // Clock, reset, requests in, applied supplies out
   input wire clk, rst,
   input wire [2:0] supplyVoltageRequest, programVoltageRequest,
   output reg [2:0] appliedSupply, appliedProgram
);
   always @(posedge clk) begin
      appliedSupply <= rst ? 3'h0 : supplyVoltageRequest;
      appliedProgram <= rst ? 3'h0 : programVoltageRequest;
   end
endmodule // socket_power_switch_model

// ===== bench/card_socket_power_clock_ctrl_tb_top.sv
// Self-checking bench of the socket power and clock block.
`timescale 1ns/10ps
module card_socket_power_clock_ctrl_tb_top;
   logic clk = 0, rst = 1, globalResetPin_n = 1, hostBusResetPin_n = 1, pmeEnable = 0, regWrite = 0, regRead = 0;
   logic card5vCapable = 1, card3vCapable = 1, socketBusy = 1, hostClockStopping = 0;
   logic [7:0] regAddr = 8'h00;
   logic [31:0] regWrData = 32'h0;
   wire [31:0] regRdData;
   wire [2:0] supplyVoltageRequest, programVoltageRequest, appliedSupply, appliedProgram;
   wire supplyRequestRefused, cardClockStopAllowed, cardClockSlowAllowed, cardClockDivEnable;
   int badCount = 0, checks = 0, cycles = 0, pulses = 0;
   typedef struct packed {logic [1:0] cap; logic [7:0] wd; logic [2:0] sup, prg; logic refu;} row_t;
   row_t rows [8] = '{'{2'h3, 8'h20, 3'h2, 3'h0, 1'h0}, '{2'h3, 8'h31, 3'h3, 3'h1, 1'h0},
      '{2'h3, 8'h02, 3'h0, 3'h2, 1'h0}, '{2'h3, 8'h13, 3'h0, 3'h3, 1'h1}, '{2'h3, 8'h74, 3'h0, 3'h3, 1'h1},
      '{2'h1, 8'h20, 3'h0, 3'h0, 1'h1}, '{2'h1, 8'h30, 3'h3, 3'h0, 1'h0}, '{2'h2, 8'h31, 3'h3, 3'h1, 1'h1}};
   card_socket_power_clock_ctrl dut (.clk, .rst, .globalResetPin_n, .hostBusResetPin_n, .pmeEnable, .regAddr,
      .regWrData, .regWrite, .regRead, .regRdData, .card5vCapable, .card3vCapable, .socketBusy, .hostClockStopping,
      .supplyVoltageRequest, .programVoltageRequest, .supplyRequestRefused, .cardClockStopAllowed,
      .cardClockSlowAllowed, .cardClockDivEnable);
   socket_power_switch_model sw (.clk, .rst, .supplyVoltageRequest, .programVoltageRequest, .appliedSupply,
      .appliedProgram);
   initial begin
      forever #50 clk = ~clk;
   end
   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         badCount++;
         $display("BAD %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1;
      @(posedge clk);
      regWrite <= 0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1;
      @(posedge clk);
      regRead <= 0;
      @(posedge clk);
      chk("read", regRdData, exp);
   endtask
   task busReset();
      hostBusResetPin_n <= 0;
      cyc(4);
      hostBusResetPin_n <= 1;
      cyc(4);
   endtask
   task finish_test();
      $display("checks %0d mismatches %0d", checks, badCount);
      if (badCount == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         badCount++;
         finish_test();
      end
   end
   initial begin
      cyc(12);
      rst <= 0;
      #1 chk("supply", supplyVoltageRequest, 0);
      chk("program", programVoltageRequest, 0);
      rd(8'h10, 32'h400);
      rd(8'h20, 32'h0);
      foreach (rows[i]) begin
         {card5vCapable, card3vCapable} <= rows[i].cap;
         cyc(4);
         wr(8'h10, {24'h0, rows[i].wd});
         cyc(3);
         chk("supply", supplyVoltageRequest, rows[i].sup);
         chk("program", programVoltageRequest, rows[i].prg);
         chk("refused", supplyRequestRefused, rows[i].refu);
         chk("applied", {appliedSupply, appliedProgram}, {rows[i].sup, rows[i].prg});
         rd(8'h10, {21'h0, 1'b1, 2'h0, 1'b0, rows[i].sup, 1'b0, rows[i].prg});
      end
      {card5vCapable, card3vCapable} <= 2'h3;
      wr(8'h10, 32'hFFFFFF80);
      rd(8'h10, 32'h480);
      wr(8'h20, 32'hFFFFFFFE);
      rd(8'h20, 32'h10000);
      cyc(6);
      chk("stop", {cardClockStopAllowed, cardClockSlowAllowed}, 2'h2);
      wr(8'h20, 32'h1);
      cyc(6);
      chk("idle", {cardClockStopAllowed, cardClockSlowAllowed}, 2'h0);
      wr(8'h20, 32'h10001);
      cyc(6);
      chk("slow", {cardClockStopAllowed, cardClockSlowAllowed}, 2'h1);
      repeat (32) begin
         @(posedge clk);
         #1 pulses += cardClockDivEnable;
      end
      chk("pulses", pulses, 2);
      wr(8'h10, 32'h0);
      wr(8'h20, 32'h10000);
      hostClockStopping <= 1;
      cyc(12);
      chk("busy", cardClockStopAllowed, 0);
      socketBusy <= 0;
      cyc(14);
      chk("idle8", cardClockStopAllowed, 1);
      hostClockStopping <= 0;
      cyc(6);
      chk("nohost", cardClockStopAllowed, 0);
      wr(8'h30, 32'hFFFFFFFF);
      rd(8'h30, 32'h0);
      wr(8'h10, 32'h31);
      pmeEnable <= 1;
      busReset();
      rd(8'h10, 32'h431);
      pmeEnable <= 0;
      busReset();
      rd(8'h10, 32'h400);
      wr(8'h10, 32'h23);
      rd(8'h10, 32'h423);
      globalResetPin_n <= 0;
      cyc(8);
      chk("global", {supplyVoltageRequest, programVoltageRequest}, 6'h0);
      globalResetPin_n <= 1;
      cyc(4);
      finish_test();
   end
endmodule // card_socket_power_clock_ctrl_tb_top
